//--- core/xsg_glue.sv
// Functional notes
// - Straps are sampled from the buffered address bus only while reset is held.
// - Speed strap 1 starts low speed, 0 starts high speed.
// - Strap decides speed only in reset; afterwards only software toggles it.
// - Any write to the speed port toggles speed, data ignored.
// - Status bit 7 shows current speed, 1 high; bit 6 reads zero.
// - Status bits 4 and 5 show the two memory-size straps.
// - Port B bit 3 low: port C shows initial-load and coprocessor straps.
// - Port B bit 3 high: port C shows video and drive-count straps.
// - Low speed: one wait state on all I/O and DMA cycles.
// - High speed: four waits on I/O, one on DMA.
// - No waits on board memory, nor on slot memory at low speed.
// - High speed: two waits on slot memory accesses.
// - Slot ready is synchronised; cycle stretches while it is low.
// - I/O addresses decode to the eight fixed windows.
// - Keyboard register is read-only; a held character raises interrupt 1.
// - Control bit 7 set clears keyboard register and its pending flag.
// - Timer 0 to irq0, timer 1 paces refresh via DMA 0, timer 2 speaker.
// - Even parity generated on RAM writes and checked on RAM reads.
// - Speed indicator is high in high speed, low in low speed.
`timescale 1ns/1ps
module xsg_glue (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] buffered_address_bus,
	input  wire logic        slot_ready_in,
	input  wire logic        cyc_start,
	input  wire logic        cyc_io,
	input  wire logic        cyc_dma,
	input  wire logic        cyc_onboard,
	input  wire logic        cyc_write,
	input  wire logic [9:0]  cyc_addr,
	input  wire logic [7:0]  cyc_wdata,
	input  wire logic        pio_port_b3,
	input  wire logic        kbd_clear,
	input  wire logic        kbd_char_valid,
	input  wire logic [7:0]  kbd_char,
	input  wire logic        timer_out0,
	input  wire logic        timer_out1,
	input  wire logic        timer_out2,
	input  wire logic        speaker_gate,
	input  wire logic        memory_parity_pin_in,
	output logic             memory_parity_pin_out,
	output logic             memory_parity_pin_oe,
	output logic             parity_error,
	output logic             cpu_clk,
	output logic             speed_indicator,
	output logic             cyc_ready,
	output logic [7:0]       io_rdata,
	output logic             io_rvalid,
	output logic [7:0]       io_select,
	output logic [3:0]       pio_port_c_cfg,
	output logic [7:0]       keyboard_char_holding,
	output logic             irq1_req,
	output logic             irq0_req,
	output logic             refresh_dma0_req,
	output logic             speaker_out
);

	// I/O window index: 0 DMA .. 7 status, 8 none
	function automatic logic [3:0] io_window(input logic [9:0] a);
		if (a >= xsg_pkg::IO_DMA_BASE && a <= xsg_pkg::IO_DMA_LAST) begin
			io_window = 4'h0;
		end else if (a >= xsg_pkg::IO_INTC_BASE && a <= xsg_pkg::IO_INTC_LAST) begin
			io_window = 4'h1;
		end else if (a >= xsg_pkg::IO_TIMER_BASE && a <= xsg_pkg::IO_TIMER_LAST) begin
			io_window = 4'h2;
		end else if (a >= xsg_pkg::IO_PIO_BASE && a <= xsg_pkg::IO_PIO_LAST) begin
			io_window = 4'h3;
		end else if (a >= xsg_pkg::IO_PAGE_BASE && a <= xsg_pkg::IO_PAGE_LAST) begin
			io_window = 4'h4;
		end else if (a >= xsg_pkg::IO_NMI_BASE && a <= xsg_pkg::IO_NMI_LAST) begin
			io_window = 4'h5;
		end else if (a >= xsg_pkg::IO_SPEED_BASE && a <= xsg_pkg::IO_SPEED_LAST) begin
			io_window = 4'h6;
		end else if (a >= xsg_pkg::IO_STATUS_BASE && a <= xsg_pkg::IO_STATUS_LAST) begin
			io_window = 4'h7;
		end else begin
			io_window = 4'h8;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	logic        rst_m_q;
	logic        rst_n;
	logic [17:0] pin_m_q;
	logic [17:0] pin_s_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_q <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n   <= rst_m_q;
		end
	end

	// Sync stays live in reset so the straps are settled when sampled
	always_ff @(posedge clk_sys) begin
		pin_m_q <= {memory_parity_pin_in, slot_ready_in, buffered_address_bus};
		pin_s_q <= pin_m_q;
	end

	logic [15:0] xbus_s;
	logic        slot_rdy_s;
	logic        par_pin_s;
	assign xbus_s     = pin_s_q[15:0];
	assign slot_rdy_s = pin_s_q[16];
	assign par_pin_s  = pin_s_q[17];

	////////////////////////////////////////////////////////////////////////////////
	// Straps and speed selection

	logic [7:0] strap_q, strap_d;
	logic       speed_req_q, speed_req_d;
	logic       speed_q, speed_d;
	logic [3:0] ccnt_q, ccnt_d;
	logic       cpu_clk_d;
	logic       cpu_tick;
	logic [3:0] div_now;
	logic [3:0] cyc_win;
	logic       speed_wr;

	always_comb begin
		cyc_win  = io_window(cyc_addr);
		speed_wr = cyc_start & cyc_io & cyc_write & (cyc_win == 4'h6);
		div_now  = speed_q ? xsg_pkg::DIV_HI : xsg_pkg::DIV_LO;
		cpu_tick = (ccnt_q == div_now - 4'h1);
		strap_d  = strap_q;
		speed_req_d = speed_req_q;
		if (!rst_n) begin
			// Pins are straps only while reset holds
			strap_d     = xbus_s[7:0];
			speed_req_d = (xbus_s[xsg_pkg::STRAP_SPEED_BIT] != xsg_pkg::STRAP_SPEED_LOW);
		end else if (speed_wr) begin
			speed_req_d = ~speed_req_q;
		end
		// Out of reset, speed follows the request only at the end of a CPU clock period
		speed_d = cpu_tick ? speed_req_q : speed_q;
		if (!rst_n) begin
			speed_d = speed_req_d;
		end
		ccnt_d    = cpu_tick ? 4'h0 : ccnt_q + 4'h1;
		// High while three times the count is below the divider: 2 of 4 clocks at high speed, 3 of 8 at low
		cpu_clk_d = ({ccnt_d, 2'b00} - {2'b00, ccnt_d} < {2'b00, div_now});
		if (cpu_tick && speed_d != speed_q) begin
			cpu_clk_d = 1'b1;
		end
	end

	// Strap and speed flops have no async reset: they load from the bus in reset
	always_ff @(posedge clk_sys) begin
		strap_q     <= strap_d;
		speed_req_q <= speed_req_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// One count before wrap, so the first high phase after reset is whole
			ccnt_q  <= 4'hF;
			cpu_clk <= 1'b0;
		end else begin
			ccnt_q  <= ccnt_d;
			cpu_clk <= cpu_clk_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		speed_q <= speed_d;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			speed_indicator <= 1'b0;
		end else begin
			speed_indicator <= speed_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wait state generator

	xsg_pkg::xsg_cyc_state_t st_q, st_d;
	logic [2:0] ws_q, ws_d;
	logic       slot_q, slot_d;
	logic       rdy_d;

	always_comb begin
		st_d   = st_q;
		ws_d   = ws_q;
		slot_d = slot_q;
		rdy_d  = 1'b0;
		unique case (st_q)
			xsg_pkg::XSG_IDLE: begin
				if (cyc_start) begin
					slot_d = ~(cyc_onboard & ~cyc_io & ~cyc_dma);
					if (cyc_dma) begin
						ws_d = xsg_pkg::WS_DMA;
					end else if (cyc_io) begin
						ws_d = speed_q ? xsg_pkg::WS_IO_HI : xsg_pkg::WS_IO_LO;
					end else if (cyc_onboard) begin
						ws_d = xsg_pkg::WS_BOARDMEM;
					end else begin
						ws_d = speed_q ? xsg_pkg::WS_SLOTMEM_HI : xsg_pkg::WS_SLOTMEM_LO;
					end
					st_d = xsg_pkg::XSG_WAIT;
				end
			end
			xsg_pkg::XSG_WAIT: begin
				if (ws_q == 3'h0) begin
					st_d = xsg_pkg::XSG_HOLD;
				end else if (cpu_tick) begin
					ws_d = ws_q - 3'h1;
				end
			end
			xsg_pkg::XSG_HOLD: begin
				// Slot devices stretch the cycle by holding ready low
				if (!slot_q || slot_rdy_s) begin
					st_d  = xsg_pkg::XSG_DONE;
					rdy_d = 1'b1;
				end
			end
			xsg_pkg::XSG_DONE: begin
				st_d = xsg_pkg::XSG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= xsg_pkg::XSG_IDLE;
			ws_q      <= 3'h0;
			slot_q    <= 1'b0;
			cyc_ready <= 1'b0;
		end else begin
			st_q      <= st_d;
			ws_q      <= ws_d;
			slot_q    <= slot_d;
			cyc_ready <= rdy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads, port C straps, keyboard holding register

	logic [7:0] rdata_d;
	logic       rvalid_d;
	logic [7:0] sel_d;
	logic [3:0] portc_d;
	logic [7:0] kbd_d;
	logic       kpend_d;

	always_comb begin
		sel_d = 8'h00;
		if (cyc_start && cyc_io && cyc_win != 4'h8) begin
			sel_d[cyc_win[2:0]] = 1'b1;
		end
		rdata_d  = xsg_pkg::RST_BYTE;
		rvalid_d = 1'b0;
		if (cyc_start && cyc_io && !cyc_write) begin
			if (cyc_win == 4'h7) begin
				rvalid_d = 1'b1;
				rdata_d[xsg_pkg::ST_SPEED_BIT] = speed_q;
				rdata_d[xsg_pkg::ST_MEM_A_BIT] = strap_q[xsg_pkg::STRAP_MEM_A_BIT];
				rdata_d[xsg_pkg::ST_MEM_B_BIT] = strap_q[xsg_pkg::STRAP_MEM_B_BIT];
			end else if (cyc_addr == xsg_pkg::IO_KBD_DATA) begin
				rvalid_d = 1'b1;
				rdata_d  = keyboard_char_holding;
			end
		end
		if (!pio_port_b3) begin
			portc_d = {2'b00,
				strap_q[xsg_pkg::STRAP_COPRO_BIT],
				strap_q[xsg_pkg::STRAP_IPL_BIT]};
		end else begin
			portc_d = {strap_q[xsg_pkg::STRAP_DRV_B_BIT], strap_q[xsg_pkg::STRAP_DRV_A_BIT],
				strap_q[xsg_pkg::STRAP_VID_B_BIT], strap_q[xsg_pkg::STRAP_VID_A_BIT]};
		end
		// A character arriving with the clear is kept: set wins
		kbd_d   = keyboard_char_holding;
		kpend_d = irq1_req;
		if (kbd_clear) begin
			kbd_d   = 8'h00;
			kpend_d = 1'b0;
		end
		if (kbd_char_valid) begin
			kbd_d   = kbd_char;
			kpend_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata              <= xsg_pkg::RST_BYTE;
			io_rvalid             <= 1'b0;
			io_select             <= 8'h00;
			pio_port_c_cfg        <= 4'h0;
			keyboard_char_holding <= xsg_pkg::RST_BYTE;
			irq1_req              <= 1'b0;
			irq0_req              <= 1'b0;
			refresh_dma0_req      <= 1'b0;
			speaker_out           <= 1'b0;
		end else begin
			io_rdata              <= rdata_d;
			io_rvalid             <= rvalid_d;
			io_select             <= sel_d;
			pio_port_c_cfg        <= portc_d;
			keyboard_char_holding <= kbd_d;
			irq1_req              <= kpend_d;
			irq0_req              <= timer_out0;
			refresh_dma0_req      <= timer_out1;
			speaker_out           <= timer_out2 & speaker_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// RAM parity

	// Data is delayed to line up with the synchronised parity pin
	logic [7:0] wdata_m_q, wdata_s_q;
	logic [1:0] mw_q, mr_q;
	logic       ram_cyc;

	assign ram_cyc = cyc_start & ~cyc_io & ~cyc_dma & cyc_onboard;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wdata_m_q <= 8'h00;
			wdata_s_q <= 8'h00;
			mw_q      <= 2'b00;
			mr_q      <= 2'b00;
		end else begin
			wdata_m_q <= cyc_wdata;
			wdata_s_q <= wdata_m_q;
			mw_q      <= {mw_q[0], ram_cyc & cyc_write};
			mr_q      <= {mr_q[0], ram_cyc & ~cyc_write};
		end
	end

	xsg_parity u_parity (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.mem_wr    (mw_q[1]),
		.mem_rd    (mr_q[1]),
		.data      (wdata_s_q),
		.par_in    (par_pin_s),
		.par_out_q (memory_parity_pin_out),
		.par_oe_q  (memory_parity_pin_oe),
		.par_err_q (parity_error)
	);

endmodule

//--- core/xsg_parity.sv
`timescale 1ns/1ps
module xsg_parity (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       mem_wr,
	input  wire logic       mem_rd,
	input  wire logic [7:0] data,
	input  wire logic       par_in,
	output logic            par_out_q,
	output logic            par_oe_q,
	output logic            par_err_q
);

	logic par_out_d;
	logic par_oe_d;
	logic par_err_d;

	// Even parity: the ninth bit makes the count of ones even
	always_comb begin
		par_out_d = ^data;
		par_oe_d  = mem_wr;
		par_err_d = mem_rd & ((^data) ^ par_in);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			par_out_q <= 1'b0;
			par_oe_q  <= 1'b0;
			par_err_q <= 1'b0;
		end else begin
			par_out_q <= par_out_d;
			par_oe_q  <= par_oe_d;
			par_err_q <= par_err_d;
		end
	end

endmodule

//--- core/xsg_pkg.sv
package xsg_pkg;

	// I/O map boundaries (10-bit CPU I/O address)
	localparam logic [9:0] IO_DMA_BASE     = 10'h000;
	localparam logic [9:0] IO_DMA_LAST     = 10'h01F;
	localparam logic [9:0] IO_INTC_BASE    = 10'h020;
	localparam logic [9:0] IO_INTC_LAST    = 10'h03F;
	localparam logic [9:0] IO_TIMER_BASE   = 10'h040;
	localparam logic [9:0] IO_TIMER_LAST   = 10'h05F;
	localparam logic [9:0] IO_PIO_BASE     = 10'h060;
	localparam logic [9:0] IO_PIO_LAST     = 10'h07F;
	localparam logic [9:0] IO_PAGE_BASE    = 10'h080;
	localparam logic [9:0] IO_PAGE_LAST    = 10'h09F;
	localparam logic [9:0] IO_NMI_BASE     = 10'h0A0;
	localparam logic [9:0] IO_NMI_LAST     = 10'h0BF;
	localparam logic [9:0] IO_SPEED_BASE   = 10'h0C0;
	localparam logic [9:0] IO_SPEED_LAST   = 10'h0C3;
	localparam logic [9:0] IO_STATUS_BASE  = 10'h0E0;
	localparam logic [9:0] IO_STATUS_LAST  = 10'h0E3;
	localparam logic [9:0] IO_KBD_DATA     = 10'h060;

	// Status register field positions
	localparam int ST_MEM_A_BIT  = 4;
	localparam int ST_MEM_B_BIT  = 5;
	localparam int ST_SPEED_BIT  = 7;

	// Strap positions on the buffered address bus
	localparam int STRAP_IPL_BIT    = 0;
	localparam int STRAP_COPRO_BIT  = 1;
	localparam int STRAP_MEM_A_BIT  = 2;
	localparam int STRAP_MEM_B_BIT  = 3;
	localparam int STRAP_VID_A_BIT  = 4;
	localparam int STRAP_VID_B_BIT  = 5;
	localparam int STRAP_DRV_A_BIT  = 6;
	localparam int STRAP_DRV_B_BIT  = 7;
	localparam int STRAP_SPEED_BIT  = 15;

	// Speed strap value that selects low speed
	localparam logic STRAP_SPEED_LOW = 1'b1;

	// Wait states in CPU clocks
	localparam logic [2:0] WS_IO_LO     = 3'h1;
	localparam logic [2:0] WS_IO_HI     = 3'h4;
	localparam logic [2:0] WS_DMA       = 3'h1;
	localparam logic [2:0] WS_SLOTMEM_LO = 3'h0;
	localparam logic [2:0] WS_SLOTMEM_HI = 3'h2;
	localparam logic [2:0] WS_BOARDMEM  = 3'h0;

	// CPU clock dividers from the 40 MHz system clock, high 2 of 4 or 3 of 8 clocks
	localparam int CLK_SYS_MHZ   = 40;
	localparam int CPU_MHZ_HI    = 10;
	localparam int CPU_MHZ_LO    = 5;
	localparam logic [3:0] DIV_HI  = 4'(CLK_SYS_MHZ / CPU_MHZ_HI);
	localparam logic [3:0] DIV_LO  = 4'(CLK_SYS_MHZ / CPU_MHZ_LO);

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [1:0] {
		XSG_IDLE = 2'b00,
		XSG_WAIT = 2'b01,
		XSG_HOLD = 2'b11,
		XSG_DONE = 2'b10
	} xsg_cyc_state_t;

endpackage

//--- verification/xsg_cpu_model.sv
`timescale 1ns/1ps
module xsg_cpu_model (
	input  wire logic       clk_sys,
	input  wire logic       cyc_ready,
	input  wire logic       io_rvalid,
	input  wire logic [7:0] io_rdata,
	input  wire logic [7:0] io_select,
	input  wire logic       parity_error,
	input  wire logic       memory_parity_pin_out,
	input  wire logic       memory_parity_pin_oe,
	output logic            cyc_start,
	output logic            cyc_io,
	output logic            cyc_dma,
	output logic            cyc_onboard,
	output logic            cyc_write,
	output logic [9:0]      cyc_addr,
	output logic [7:0]      cyc_wdata,
	output logic            slot_ready_in,
	output logic            memory_parity_pin_in
);
	logic ram_par_q, rd_act, bad_par, float_q;
	initial begin
		{cyc_start, cyc_io, cyc_dma, cyc_onboard, cyc_write, rd_act, bad_par, ram_par_q} = '0;
		{cyc_addr, cyc_wdata, float_q} = '0;
		slot_ready_in = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One parity cell only; the pin toggles when nobody drives it, so a float never matches
	always @(posedge clk_sys) begin
		if (memory_parity_pin_oe) ram_par_q <= memory_parity_pin_out;
		float_q <= ~float_q;
	end
	// Stored bit stands from the start edge on, where the glue takes the pin
	assign memory_parity_pin_in = rd_act ? ram_par_q ^ bad_par : float_q;
	// Kind is {io, dma, onboard, write}; qualifiers stand until ready is seen
	task automatic run(input logic [3:0] k, input logic [9:0] a, input logic [7:0] d,
			input int stall, input logic bad, output logic [7:0] rd, output logic [7:0] sel,
			output logic rv, output logic perr, output int n);
		{rd, sel, rv, perr} = '0;
		n = 0;
		@(posedge clk_sys);
		{cyc_io, cyc_dma, cyc_onboard, cyc_write} <= k;
		cyc_addr <= a;
		cyc_wdata <= d;
		cyc_start <= 1'b1;
		rd_act <= k == 4'h2;
		bad_par <= bad;
		slot_ready_in <= stall == 0;
		@(posedge clk_sys);
		cyc_start <= 1'b0;
		while (!cyc_ready && n < 200) begin
			@(posedge clk_sys);
			if (n == 0) {rv, rd, sel} = {io_rvalid, io_rdata, io_select};
			perr |= parity_error;
			n++;
			if (n >= stall) slot_ready_in <= 1'b1;
		end
		repeat (2) begin
			@(posedge clk_sys);
			perr |= parity_error;
		end
		rd_act <= 1'b0;
	endtask
endmodule

//--- verification/xsg_glue_sva.sv
`timescale 1ns/1ps
module xsg_glue_sva (
	input wire logic       clk_sys,
	input wire logic       reset_n,
	input wire logic       cyc_start,
	input wire logic       cyc_io,
	input wire logic       cyc_dma,
	input wire logic       cyc_onboard,
	input wire logic       cyc_write,
	input wire logic [9:0] cyc_addr,
	input wire logic [7:0] cyc_wdata,
	input wire logic       kbd_char_valid,
	input wire logic [7:0] kbd_char,
	input wire logic       kbd_clear,
	input wire logic       memory_parity_pin_out,
	input wire logic       memory_parity_pin_oe,
	input wire logic       speed_indicator,
	input wire logic       cpu_clk,
	input wire logic       cyc_ready,
	input wire logic [7:0] io_rdata,
	input wire logic       io_rvalid,
	input wire logic [7:0] io_select,
	input wire logic [7:0] keyboard_char_holding,
	input wire logic       irq1_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic io_rd, spd_wr, ram, sref_q;
	assign io_rd = cyc_start && cyc_io && !cyc_write;
	assign spd_wr = cyc_start && cyc_io && cyc_write && cyc_addr inside {[10'h0C0:10'h0C3]};
	assign ram = cyc_start && !cyc_io && !cyc_dma && cyc_onboard;
	// Speed at the toggle write, so any later toggle is judged against it
	always_ff @(posedge clk_sys) if (spd_wr) sref_q <= speed_indicator;
	function automatic logic [7:0] sel_of(logic [9:0] a);
		if (a inside {[10'h0C0:10'h0C3]}) return 8'h40;
		if (a inside {[10'h0E0:10'h0E3]}) return 8'h80;
		return (a < 10'h0C0) ? 8'h01 << a[7:5] : 8'h00;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	spd_toggle_a: assert property (spd_wr |=> ##[0:13] speed_indicator != sref_q)
		else $error("speed did not toggle after a speed write");
	stat_read_a: assert property (io_rd && cyc_addr inside {[10'h0E0:10'h0E3]} |=>
		io_rvalid && io_rdata[7] == speed_indicator && !io_rdata[6])
		else $error("status read shows wrong speed");
	sel_dec_a: assert property (cyc_start && cyc_io |=> io_select == sel_of($past(cyc_addr)))
		else $error("wrong io window select");
	kbd_load_a: assert property (kbd_char_valid |=>
		irq1_req && keyboard_char_holding == $past(kbd_char))
		else $error("keyboard character not held");
	kbd_clr_a: assert property (kbd_clear && !kbd_char_valid |=>
		!irq1_req && keyboard_char_holding == 8'h00)
		else $error("keyboard register not cleared");
	board_nowait_a: assert property (ram |-> ##3 cyc_ready)
		else $error("board memory cycle was stretched");
	io_lo_a: assert property (io_rd && !speed_indicator |=> (!cyc_ready)[*3] ##[1:24] cyc_ready)
		else $error("low speed io wait count wrong");
	clk_high_a: assert property ($rose(cpu_clk) |=> cpu_clk)
		else $error("cpu clock high phase too short");
	clk_low_a: assert property ($fell(cpu_clk) |=> !cpu_clk)
		else $error("cpu clock low phase too short");
	io_hi_a: assert property (io_rd && speed_indicator |=> (!cyc_ready)[*8] ##[1:30] cyc_ready)
		else $error("high speed io wait count wrong");
	slot_hi_a: assert property (cyc_start && !cyc_io && !cyc_dma && !cyc_onboard &&
		speed_indicator |=> (!cyc_ready)[*5] ##[1:24] cyc_ready)
		else $error("high speed slot memory wait count wrong");
	par_gen_a: assert property (ram && cyc_write |-> ##3 memory_parity_pin_oe &&
		memory_parity_pin_out == ^$past(cyc_wdata, 3))
		else $error("write parity bit wrong");
endmodule
bind xsg_glue xsg_glue_sva u_sva (.clk_sys, .reset_n, .cyc_start, .cyc_io, .cyc_dma, .cyc_onboard,
	.cyc_write, .cyc_addr, .cyc_wdata, .kbd_char_valid, .kbd_char, .kbd_clear,
	.memory_parity_pin_out, .memory_parity_pin_oe, .speed_indicator, .cpu_clk, .cyc_ready, .io_rdata,
	.io_rvalid, .io_select, .keyboard_char_holding, .irq1_req);

//--- verification/xsg_glue_tb.sv
`timescale 1ns/1ps
module xsg_glue_tb;
	logic        clk_sys, reset_n, pio_port_b3, kbd_clear, kbd_char_valid, rv, perr;
	logic        timer_out0, timer_out1, timer_out2, speaker_gate, slot_ready_in, cyc_start;
	logic        cyc_io, cyc_dma, cyc_onboard, cyc_write, parity_error, cpu_clk, cyc_ready;
	logic        memory_parity_pin_in, memory_parity_pin_out, memory_parity_pin_oe, io_rvalid;
	logic        speed_indicator, irq1_req, irq0_req, refresh_dma0_req, speaker_out;
	logic [15:0] buffered_address_bus;
	logic [9:0]  cyc_addr;
	logic [7:0]  cyc_wdata, kbd_char, io_rdata, io_select, keyboard_char_holding, rd, sel;
	logic [3:0]  pio_port_c_cfg;
	int          err_count, checks, n;
	localparam logic [9:0] SEL_A [10] = '{10'h000, 10'h03F, 10'h040, 10'h07F, 10'h080,
		10'h0BF, 10'h0C2, 10'h0C4, 10'h0E1, 10'h0E4};
	localparam logic [7:0] SEL_E [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
		8'h00, 8'h80, 8'h00};
	xsg_glue u_xsg_glue (.clk_sys, .reset_n, .buffered_address_bus, .slot_ready_in, .cyc_start,
		.cyc_io, .cyc_dma, .cyc_onboard, .cyc_write, .cyc_addr, .cyc_wdata, .pio_port_b3,
		.kbd_clear, .kbd_char_valid, .kbd_char, .timer_out0, .timer_out1, .timer_out2,
		.speaker_gate, .memory_parity_pin_in, .memory_parity_pin_out, .memory_parity_pin_oe,
		.parity_error, .cpu_clk, .speed_indicator, .cyc_ready, .io_rdata, .io_rvalid, .io_select,
		.pio_port_c_cfg, .keyboard_char_holding, .irq1_req, .irq0_req, .refresh_dma0_req,
		.speaker_out);
	xsg_cpu_model u_xsg_cpu_model (.clk_sys, .cyc_ready, .io_rvalid, .io_rdata, .io_select,
		.parity_error, .memory_parity_pin_out, .memory_parity_pin_oe, .cyc_start, .cyc_io,
		.cyc_dma, .cyc_onboard, .cyc_write, .cyc_addr, .cyc_wdata, .slot_ready_in,
		.memory_parity_pin_in);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input logic [3:0] k, input logic [9:0] a, input logic [7:0] d,
			input int stall, input logic bad);
		u_xsg_cpu_model.run(k, a, d, stall, bad, rd, sel, rv, perr, n);
		if (n >= 200) begin
			err_count++;
			print_verdict();
		end
	endtask
	// Long hold so the straps clear the input synchroniser before release
	task automatic do_reset(input logic [15:0] straps);
		reset_n <= 1'b0;
		buffered_address_bus <= straps;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic port_c(input logic [3:0] lo, input logic [3:0] hi);
		pio_port_b3 <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(16'(pio_port_c_cfg), 16'(lo));
		pio_port_b3 <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(16'(pio_port_c_cfg), 16'(hi));
	endtask
	task automatic spd_write(input logic [9:0] a, input logic [7:0] d);
		cyc(4'h9, a, d, 0, 1'b0);
		repeat (12) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, pio_port_b3, kbd_clear, kbd_char_valid, kbd_char, buffered_address_bus} = '0;
		{timer_out0, timer_out1, timer_out2, speaker_gate, err_count, checks} = '0;
		do_reset(16'h806D);
		chk(16'(speed_indicator), 16'h0000);
		cyc(4'h8, 10'h0E0, 8'h00, 0, 1'b0);
		chk(16'(rd), 16'h0030);
		port_c(4'h1, 4'h6);
		buffered_address_bus <= 16'h7F92;
		repeat (4) @(posedge clk_sys);
		port_c(4'h1, 4'h6);
		chk(16'(speed_indicator), 16'h0000);
		for (int i = 0; i < 2; i++) begin
			spd_write(10'h0C0 + 10'(i * 3), 8'h55 ^ 8'(i));
			chk(16'(speed_indicator), 16'(i == 0));
			cyc(4'h8, 10'h0E3, 8'h00, 0, 1'b0);
			chk(16'(rd), i == 0 ? 16'h00B0 : 16'h0030);
		end
		for (int i = 0; i < 10; i++) begin
			cyc(4'h8, SEL_A[i], 8'h00, 0, 1'b0);
			chk(16'(sel), 16'(SEL_E[i]));
		end
		kbd_char <= 8'hA5;
		kbd_char_valid <= 1'b1;
		@(posedge clk_sys);
		kbd_char_valid <= 1'b0;
		@(posedge clk_sys);
		chk(16'({irq1_req, keyboard_char_holding}), 16'h01A5);
		cyc(4'h9, 10'h060, 8'h3C, 0, 1'b0);
		cyc(4'h8, 10'h060, 8'h00, 0, 1'b0);
		chk(16'({rv, rd}), 16'h01A5);
		kbd_clear <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(16'({irq1_req, keyboard_char_holding}), 16'h0000);
		kbd_clear <= 1'b0;
		cyc(4'h3, 10'h000, 8'h07, 0, 1'b0);
		chk(16'(n), 16'h0003);
		cyc(4'h2, 10'h000, 8'h07, 0, 1'b0);
		chk(16'(perr), 16'h0000);
		cyc(4'h2, 10'h000, 8'h07, 0, 1'b1);
		chk(16'(perr), 16'h0001);
		cyc(4'h0, 10'h000, 8'h00, 12, 1'b0);
		chk(16'(n > 12), 16'h0001);
		cyc(4'h4, 10'h000, 8'h00, 0, 1'b0);
		chk(16'(n inside {[4:11]}), 16'h0001);
		spd_write(10'h0C1, 8'hFF);
		cyc(4'h0, 10'h000, 8'h00, 0, 1'b0);
		chk(16'(n inside {[8:11]}), 16'h0001);
		cyc(4'h4, 10'h000, 8'h00, 0, 1'b0);
		chk(16'(n inside {[4:7]}), 16'h0001);
		cyc(4'h3, 10'h000, 8'h80, 0, 1'b0);
		spd_write(10'h0C2, 8'h00);
		{timer_out0, timer_out1, timer_out2, speaker_gate} <= 4'hF;
		repeat (2) @(posedge clk_sys);
		chk(16'({irq0_req, refresh_dma0_req, speaker_out}), 16'h0007);
		{timer_out1, speaker_gate} <= 2'h0;
		repeat (2) @(posedge clk_sys);
		chk(16'({irq0_req, refresh_dma0_req, speaker_out}), 16'h0004);
		do_reset(16'h007A);
		chk(16'(speed_indicator), 16'h0001);
		cyc(4'h8, 10'h0E0, 8'h00, 0, 1'b0);
		chk(16'(rd), 16'h00A0);
		port_c(4'h2, 4'h7);
		print_verdict();
	end
endmodule
